// file: hw/rpsel_pkg.sv
// Types shared by the pin select block.
`default_nettype none

package rpsel_pkg;

	parameter int RPSEL_NPIN  = 182;
	parameter int RPSEL_NFUNC = 64;

	typedef logic [7:0] rpsel_code_t;
	typedef logic [5:0] rpsel_func_t;

	// Peripheral inputs delivered by the remap.
	typedef struct packed {
		logic uart2_cts;
		logic uart2_rx;
		logic spi1_clk;
		logic spi1_din;
		logic spi1_slvsel;
		logic spi2_clk;
		logic spi2_din;
		logic spi2_slvsel;
		logic pwm_sync_in1;
		logic pwm_sync_in2;
		logic pwm_fault5;
		logic pwm_fault6;
		logic pwm_fault7;
		logic pwm_fault8;
	} rpsel_periph_in_t;

	// Data phase bookkeeping for a pending write.
	typedef struct packed {
		logic       valid;
		logic [3:0] idx;
	} rpsel_wr_t;

endpackage

`default_nettype wire

// file: hw/rpsel_regs.svh
// Register indices, field positions, masks and reset values of the pin select block.
`ifndef RPSEL_REGS_SVH
`define RPSEL_REGS_SVH

// Word index of each register; the byte address is four times the index.
`define RPSEL_IDX_UART2     4'd0
`define RPSEL_IDX_SPI1_CD   4'd1
`define RPSEL_IDX_SPI1_SS   4'd2
`define RPSEL_IDX_SPI2_CD   4'd3
`define RPSEL_IDX_SPI2_SS   4'd4
`define RPSEL_IDX_SYNC1     4'd5
`define RPSEL_IDX_SYNC2     4'd6
`define RPSEL_IDX_FLT56     4'd7
`define RPSEL_IDX_FLT78     4'd8
`define RPSEL_IDX_OUT3233   4'd9
`define RPSEL_IDX_OUT3435   4'd10
`define RPSEL_NREG          11

// Implemented (writable, readable) bits of each register.
`define RPSEL_MASK_BOTH     16'hffff
`define RPSEL_MASK_LOW      16'h00ff
`define RPSEL_MASK_HIGH     16'hff00
`define RPSEL_MASK_OUT      16'h3f3f

`define RPSEL_RST           16'h0000
`define RPSEL_CODE_GND      8'h00
`define RPSEL_CODE_MAX      8'hb5
`define RPSEL_FUNC_NONE     6'h00
`define RPSEL_IN_LSB        0
`define RPSEL_IN_MSB        8
`define RPSEL_OUT_LSB       0
`define RPSEL_OUT_MSB       8

`endif

// file: hw/rpsel_top.sv
// Remappable pin select: selector registers on AHB-Lite, input and output muxes.
`timescale 1ns/10ps
`default_nettype none
`include "rpsel_regs.svh"

module rpsel_top
	import rpsel_pkg::*;
(
	input  wire logic                   hclk,        // System clock, 40 MHz.
	input  wire logic                   hresetn,     // Async reset, low.
	input  wire logic                   hsel,        // Slave select.
	input  wire logic [31:0]            haddr,       // Byte address.
	input  wire logic [1:0]             htrans,      // Transfer type.
	input  wire logic                   hwrite,      // Write when high.
	input  wire logic [2:0]             hsize,       // Transfer size.
	input  wire logic [31:0]            hwdata,      // Write data.
	input  wire logic                   hready,      // Bus ready in.
	output logic                        hreadyout,   // Slave ready.
	output logic                        hresp,       // Always OKAY.
	output logic [31:0]                 hrdata,      // Read data.
	input  wire logic [RPSEL_NPIN-1:0]  remappable_pin,  // Pin levels.
	input  wire logic [RPSEL_NFUNC-1:0] periph_out_func, // Output functions.
	output rpsel_periph_in_t            periph_in,   // Routed inputs.
	output logic [3:0]                  out_pin      // Pins 32 to 35.
);

	logic [15:0]      reg_q [`RPSEL_NREG];
	logic [15:0]      reg_d [`RPSEL_NREG];
	logic [15:0]      mask  [`RPSEL_NREG];
	rpsel_wr_t        wr_q;
	rpsel_wr_t        wr_d;
	logic [31:0]      rdata_q;
	logic [31:0]      rdata_d;
	logic             ready_q;
	logic [RPSEL_NPIN-1:0] pin_s1_q;
	logic [RPSEL_NPIN-1:0] pin_s2_q;
	rpsel_code_t      sel [14];
	logic [13:0]      route_d;
	logic [13:0]      route_q;
	rpsel_func_t      fsel [4];
	logic [3:0]       opin_d;
	logic [3:0]       opin_q;
	logic             addr_ok;
	logic [3:0]       addr_idx;

	assign addr_idx = haddr[5:2];
	assign addr_ok  = hsel && hready && htrans[1];

	// Writable bits per register; the rest stay zero forever.
	always_comb begin
		mask[`RPSEL_IDX_UART2]   = `RPSEL_MASK_BOTH;
		mask[`RPSEL_IDX_SPI1_CD] = `RPSEL_MASK_BOTH;
		mask[`RPSEL_IDX_SPI1_SS] = `RPSEL_MASK_LOW;
		mask[`RPSEL_IDX_SPI2_CD] = `RPSEL_MASK_BOTH;
		mask[`RPSEL_IDX_SPI2_SS] = `RPSEL_MASK_LOW;
		mask[`RPSEL_IDX_SYNC1]   = `RPSEL_MASK_HIGH;
		mask[`RPSEL_IDX_SYNC2]   = `RPSEL_MASK_LOW;
		mask[`RPSEL_IDX_FLT56]   = `RPSEL_MASK_BOTH;
		mask[`RPSEL_IDX_FLT78]   = `RPSEL_MASK_BOTH;
		mask[`RPSEL_IDX_OUT3233] = `RPSEL_MASK_OUT;
		mask[`RPSEL_IDX_OUT3435] = `RPSEL_MASK_OUT;
	end

	// Register file and bus slave next state.
	always_comb begin
		for (int i = 0; i < `RPSEL_NREG; i++) begin
			reg_d[i] = reg_q[i];
			if (wr_q.valid && wr_q.idx == 4'(i)) begin
				reg_d[i] = (hwdata[15:0] & mask[i]) |
				           (reg_q[i] & ~mask[i]);
			end
		end
		wr_d.valid = addr_ok && hwrite && haddr[7:6] == 2'b00;
		wr_d.idx   = addr_idx;
		// A read right after a write sees the new value, so read the
		// next-state copy rather than the stored one.
		rdata_d = 32'h0000_0000;
		if (addr_ok && !hwrite && haddr[7:6] == 2'b00 &&
		    addr_idx < 4'(`RPSEL_NREG)) begin
			rdata_d = {16'h0000, reg_d[addr_idx]};
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < `RPSEL_NREG; i++) begin
				reg_q[i] <= `RPSEL_RST;
			end
			wr_q    <= '0;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b1;
		end else begin
			for (int i = 0; i < `RPSEL_NREG; i++) begin
				reg_q[i] <= reg_d[i];
			end
			wr_q    <= wr_d;
			rdata_q <= rdata_d;
			ready_q <= 1'b1;
		end
	end

	assign hreadyout = ready_q;
	assign hrdata    = rdata_q;
	assign hresp     = 1'b0;

	// Pins are asynchronous to hclk; two flops before any mux reads them.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
		end else begin
			pin_s1_q <= remappable_pin;
			pin_s2_q <= pin_s1_q;
		end
	end

	// Selector fields, in the bit order of the routed input bundle.
	always_comb begin
		sel[13] = reg_q[`RPSEL_IDX_UART2][15:8];
		sel[12] = reg_q[`RPSEL_IDX_UART2][7:0];
		sel[11] = reg_q[`RPSEL_IDX_SPI1_CD][15:8];
		sel[10] = reg_q[`RPSEL_IDX_SPI1_CD][7:0];
		sel[9]  = reg_q[`RPSEL_IDX_SPI1_SS][7:0];
		sel[8]  = reg_q[`RPSEL_IDX_SPI2_CD][15:8];
		sel[7]  = reg_q[`RPSEL_IDX_SPI2_CD][7:0];
		sel[6]  = reg_q[`RPSEL_IDX_SPI2_SS][7:0];
		sel[5]  = reg_q[`RPSEL_IDX_SYNC1][15:8];
		sel[4]  = reg_q[`RPSEL_IDX_SYNC2][7:0];
		sel[3]  = reg_q[`RPSEL_IDX_FLT56][7:0];
		sel[2]  = reg_q[`RPSEL_IDX_FLT56][15:8];
		sel[1]  = reg_q[`RPSEL_IDX_FLT78][7:0];
		sel[0]  = reg_q[`RPSEL_IDX_FLT78][15:8];
	end

	// Codes above the last pin are not defined; they read as ground too,
	// so a stray code can never pick up a floating level.
	always_comb begin
		for (int k = 0; k < 14; k++) begin
			if (sel[k] == `RPSEL_CODE_GND ||
			    sel[k] > `RPSEL_CODE_MAX) begin
				route_d[k] = 1'b0;
			end else begin
				route_d[k] = pin_s2_q[sel[k]];
			end
		end
	end

	// Output function selectors for pins 32 to 35.
	always_comb begin
		fsel[0] = reg_q[`RPSEL_IDX_OUT3233][5:0];
		fsel[1] = reg_q[`RPSEL_IDX_OUT3233][13:8];
		fsel[2] = reg_q[`RPSEL_IDX_OUT3435][5:0];
		fsel[3] = reg_q[`RPSEL_IDX_OUT3435][13:8];
		for (int k = 0; k < 4; k++) begin
			if (fsel[k] == `RPSEL_FUNC_NONE) begin
				opin_d[k] = 1'b0;
			end else begin
				opin_d[k] = periph_out_func[fsel[k]];
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			route_q <= '0;
			opin_q  <= '0;
		end else begin
			route_q <= route_d;
			opin_q  <= opin_d;
		end
	end

	assign periph_in = rpsel_periph_in_t'(route_q);
	assign out_pin   = opin_q;

	// Helper values that the checks below compare against.
	logic rx_ref;
	logic o32_ref;
	assign rx_ref  = pin_s2_q[sel[12]];
	assign o32_ref = periph_out_func[fsel[0]];

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	sequence rd_at(logic [3:0] idx);
		addr_ok && !hwrite && haddr[7:6] == 2'b00 && addr_idx == idx;
	endsequence

	sequence wr_at(logic [3:0] idx);
		addr_ok && hwrite && haddr[7:6] == 2'b00 && addr_idx == idx;
	endsequence

	pin_route_a: assert property (
		sel[12] != 8'h00 && sel[12] <= 8'hb5
		|=> periph_in.uart2_rx == $past(rx_ref))
		else $error("receive input does not follow its pin");

	pin_one_a: assert property (
		sel[12] == 8'h01 |=> periph_in.uart2_rx == $past(pin_s2_q[1]))
		else $error("code one does not select pin 1");

	pin_max_a: assert property (
		sel[12] == 8'hb5 |=> periph_in.uart2_rx == $past(pin_s2_q[181]))
		else $error("top code does not select pin 181");

	gnd_tie_a: assert property (
		sel[13] == 8'h00 |=> !periph_in.uart2_cts)
		else $error("zero code does not tie input low");

	uart_split_a: assert property (
		wr_at(`RPSEL_IDX_UART2) ##1 1'b1
		|=> sel[13] == $past(hwdata[15:8], 1) &&
		    sel[12] == $past(hwdata[7:0], 1))
		else $error("uart selector bytes misplaced");

	spi1_split_a: assert property (
		wr_at(`RPSEL_IDX_SPI1_CD) ##1 1'b1
		|=> sel[11] == $past(hwdata[15:8], 1) &&
		    sel[10] == $past(hwdata[7:0], 1))
		else $error("spi1 selector bytes misplaced");

	ss1_upper_a: assert property (
		rd_at(`RPSEL_IDX_SPI1_SS) |=> hrdata[31:8] == 24'h000000)
		else $error("spi1 select upper byte not zero");

	ss2_gnd_a: assert property (
		sel[6] == 8'h00 ##1 sel[6] == 8'h00 |-> !periph_in.spi2_slvsel)
		else $error("spi2 select not grounded");

	sync1_low_a: assert property (
		rd_at(`RPSEL_IDX_SYNC1) |=> hrdata[7:0] == 8'h00 && hreadyout)
		else $error("sync1 low byte not zero");

	sync2_high_a: assert property (
		rd_at(`RPSEL_IDX_SYNC2) |=> hrdata[31:8] == 24'h000000)
		else $error("sync2 upper byte not zero");

	out_func_a: assert property (
		fsel[0] != 6'h00 |=> out_pin[0] == $past(o32_ref))
		else $error("pin 32 does not follow its function");

	out_rsvd_a: assert property (
		rd_at(`RPSEL_IDX_OUT3435)
		|=> hrdata[15:14] == 2'b00 && hrdata[7:6] == 2'b00)
		else $error("output register reserved bits set");

	wr_back_a: assert property (
		wr_at(`RPSEL_IDX_SPI2_CD) ##1 1'b1
		|=> reg_q[`RPSEL_IDX_SPI2_CD] == $past(hwdata[15:0], 1))
		else $error("write not stored");

	ss1_write_a: assert property (
		wr_at(`RPSEL_IDX_SPI1_SS) ##1 1'b1
		|=> reg_q[`RPSEL_IDX_SPI1_SS] == {8'h00, $past(hwdata[7:0], 1)})
		else $error("spi1 select write not confined to low byte");

	ss2_write_a: assert property (
		wr_at(`RPSEL_IDX_SPI2_SS) ##1 1'b1
		|=> reg_q[`RPSEL_IDX_SPI2_SS] == {8'h00, $past(hwdata[7:0], 1)})
		else $error("spi2 select write not confined to low byte");

	sync1_write_a: assert property (
		wr_at(`RPSEL_IDX_SYNC1) ##1 1'b1
		|=> reg_q[`RPSEL_IDX_SYNC1] == {$past(hwdata[15:8], 1), 8'h00})
		else $error("sync1 write not confined to upper byte");

	sync2_write_a: assert property (
		wr_at(`RPSEL_IDX_SYNC2) ##1 1'b1
		|=> reg_q[`RPSEL_IDX_SYNC2] == {8'h00, $past(hwdata[7:0], 1)})
		else $error("sync2 write not confined to low byte");

	out_mask_a: assert property (
		wr_at(`RPSEL_IDX_OUT3233) ##1 1'b1
		|=> reg_q[`RPSEL_IDX_OUT3233] ==
		    ($past(hwdata[15:0], 1) & `RPSEL_MASK_OUT))
		else $error("output register keeps reserved bits");

	rd_data_a: assert property (
		rd_at(`RPSEL_IDX_UART2)
		|=> hrdata == {16'h0000, reg_q[`RPSEL_IDX_UART2]})
		else $error("read data differs from register");

	out_off_a: assert property (
		fsel[1] == 6'h00 |=> !out_pin[1])
		else $error("pin 33 driven with no function");

endmodule // rpsel_top

`default_nettype wire

// file: tb/rpsel_far_model.sv
// Far side of the pin select block: remappable pin levels and output functions.
`timescale 1ns/10ps
`default_nettype none

module rpsel_far_model
	import rpsel_pkg::*;
(
	input  wire logic             inv,             // Flip every level.
	output logic [RPSEL_NPIN-1:0]  remappable_pin,  // Pin levels.
	output logic [RPSEL_NFUNC-1:0] periph_out_func  // Function levels.
);
	// Levels follow the parity of the number, so neighbouring codes differ.
	// A route to a neighbouring pin therefore shows up as a wrong level.
	assign remappable_pin  = {(RPSEL_NPIN / 2){2'b10}} ^ {RPSEL_NPIN{inv}};
	assign periph_out_func = {(RPSEL_NFUNC / 2){2'b10}} ^ {RPSEL_NFUNC{inv}};
endmodule // rpsel_far_model

`default_nettype wire

// file: tb/rpsel_top_tb.sv
// Self-checking bench for the pin select block over AHB-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "rpsel_regs.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin num_errors++; \
	$display("unexpected %s: expected %h, seen %h", nm, e, g); end end

module rpsel_top_tb
	import rpsel_pkg::*;
;
	logic                   hclk = 1'b0;
	logic                   hresetn = 1'b0;
	logic                   hsel = 1'b0;
	logic                   hwrite = 1'b0;
	logic                   inv = 1'b0;
	logic [31:0]            haddr = 32'h0;
	logic [31:0]            hwdata = 32'h0;
	logic [31:0]            rd;
	logic [31:0]            want;
	logic [1:0]             htrans = 2'h0;
	logic [2:0]             hsize = 3'h2;
	logic                   hreadyout;
	logic                   hresp;
	logic [31:0]            hrdata;
	logic [RPSEL_NPIN-1:0]  pins;
	logic [RPSEL_NFUNC-1:0] funcs;
	rpsel_periph_in_t       periph_in;
	logic [3:0]             out_pin;
	int                     num_errors = 0;
	int                     checked = 0;
	logic [15:0] masks [11] = '{`RPSEL_MASK_BOTH, `RPSEL_MASK_BOTH,
		`RPSEL_MASK_LOW, `RPSEL_MASK_BOTH, `RPSEL_MASK_LOW, `RPSEL_MASK_HIGH,
		`RPSEL_MASK_LOW, `RPSEL_MASK_BOTH, `RPSEL_MASK_BOTH, `RPSEL_MASK_OUT,
		`RPSEL_MASK_OUT};
	// Register and shift of each routed input, from the top bit of periph_in.
	int          fld_reg [14] = '{0, 0, 1, 1, 2, 3, 3, 4, 5, 6, 7, 7, 8, 8};
	int          fld_sh [14]  = '{8, 0, 8, 0, 0, 8, 0, 0, 8, 0, 0, 8, 0, 8};
	logic [7:0]  codes [5]    = '{8'h01, 8'hb5, 8'hb4, 8'h00, 8'hb6};
	logic [5:0]  fcodes [4]   = '{6'h00, 6'h01, 6'h3f, 6'h2a};

	always #12.5 hclk = ~hclk;

	rpsel_top uut (
		.hclk            (hclk),
		.hresetn         (hresetn),
		.hsel            (hsel),
		.haddr           (haddr),
		.htrans          (htrans),
		.hwrite          (hwrite),
		.hsize           (hsize),
		.hwdata          (hwdata),
		.hready          (hreadyout),
		.hreadyout       (hreadyout),
		.hresp           (hresp),
		.hrdata          (hrdata),
		.remappable_pin  (pins),
		.periph_out_func (funcs),
		.periph_in       (periph_in),
		.out_pin         (out_pin)
	);

	rpsel_far_model far (
		.inv             (inv),
		.remappable_pin  (pins),
		.periph_out_func (funcs)
	);

	// One single transfer; entered and left at a rising edge.
	task automatic xfer(input logic w, input int idx, input logic [31:0] wd);
		hsel <= 1'b1;
		haddr <= 32'(idx * 4);
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1) @(posedge hclk);
		rd = hrdata;
	endtask

	// Covers the two synchroniser flops and the output flop.
	task automatic settle;
		repeat (4) @(posedge hclk);
	endtask

	function automatic logic pin_lvl(input logic [7:0] c);
		return (c >= 8'h01 && c <= `RPSEL_CODE_MAX) ? (c[0] ^ inv) : 1'b0;
	endfunction

	task automatic results;
		if (num_errors == 0 && checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		`CHK("ready", 1'b1, hreadyout)
		for (int i = 0; i < `RPSEL_NREG; i++) begin
			xfer(1'b0, i, 32'h0);
			`CHK("reset value", 32'h0, rd)
		end
		for (int i = 0; i < `RPSEL_NREG; i++) begin
			xfer(1'b1, i, 32'hffffffff);
			xfer(1'b0, i, 32'h0);
			want = {16'h0, masks[i]};
			`CHK("impl bits", want, rd)
		end
		xfer(1'b1, 11, 32'h0000ffff);
		xfer(1'b0, 11, 32'h0);
		`CHK("unmapped read", 32'h0, rd)
		`CHK("response", 1'b0, hresp)
		// An address with bit 6 set must not alias onto the first register.
		xfer(1'b1, 16, 32'h0);
		xfer(1'b0, 0, 32'h0);
		`CHK("alias write", 32'h0000ffff, rd)
		for (int i = 0; i < `RPSEL_NREG; i++) xfer(1'b1, i, 32'h0);
		for (int k = 0; k < 14; k++) begin
			for (int j = 0; j < 5; j++) begin
				for (int v = 0; v < 2; v++) begin
					inv <= v[0];
					xfer(1'b1, fld_reg[k], 32'(codes[j]) << fld_sh[k]);
					settle();
					want = 32'(pin_lvl(codes[j])) << (13 - k);
					`CHK("routed input", want[13:0], periph_in)
				end
			end
			xfer(1'b1, fld_reg[k], 32'h0);
		end
		for (int p = 0; p < 4; p++) begin
			for (int j = 0; j < 4; j++) begin
				for (int v = 0; v < 2; v++) begin
					inv <= v[0];
					xfer(1'b1, 9 + p / 2, 32'(fcodes[j]) << (8 * (p % 2)));
					settle();
					want = 32'(fcodes[j][0] ^ inv) << p;
					if (fcodes[j] == 6'h00) begin
						want = 32'h0;
					end
					`CHK("output pin", want[3:0], out_pin)
				end
			end
			xfer(1'b1, 9 + p / 2, 32'h0);
		end
		// Leave live routes in place so that the reset has something to clear.
		inv <= 1'b1;
		xfer(1'b1, 0, 32'h00001234);
		xfer(1'b1, 9, 32'h00000202);
		settle();
		`CHK("pre reset routes", 14'h3000, periph_in)
		`CHK("pre reset pins", 4'h3, out_pin)
		hresetn <= 1'b0;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		xfer(1'b0, 0, 32'h0);
		`CHK("reset clears", 32'h0, rd)
		`CHK("reset routes", 14'h0, periph_in)
		`CHK("reset pins", 4'h0, out_pin)
		results();
	end

	// The whole sequence needs about 1200 cycles; this bound cuts a hang.
	initial begin
		repeat (20000) @(posedge hclk);
		num_errors++;
		results();
	end
endmodule // rpsel_top_tb

`default_nettype wire
